// >>> design/bwuc_regs.v
// Function
// - limit word bit 0 mirrors prefetch width cap
// - limit low holds A31:20, low bits ones
// - base, limit and uppers form prefetch window
// - base upper gives A63:32, resets all ones
// - limit upper gives A63:32, resets zero
// - narrow prefetch: uppers read zero, ignore writes
// - I/O uppers, base resets ffff, limit zero
// - narrow I/O: uppers read zero, ignore writes
// - capability head resets 40h, lock gated
// - option ROM base reads zero, drops writes
// - irq routing line stored, unused otherwise
// - width cap 1 means 64-bit, lock gated
//
// The APB register port was decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "bwuc_defines.vh"
module bwuc_regs (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [3:0] pstrb_i,
  output wire pready_o,
  output wire [31:0] prdata_o,
  output wire pslverr_o,
  input wire reg_lock_i,
  input wire [11:0] prefetch_base_low_i,
  input wire io_width_cap_i,
  input wire [3:0] io_base_low_i,
  input wire [3:0] io_limit_low_i,
  input wire [63:0] mem_addr_i,
  input wire [31:0] io_addr_i,
  output reg prefetch_width_cap_o,
  output reg [63:0] pf_base_o,
  output reg [63:0] pf_limit_o,
  output reg [31:0] io_base_o,
  output reg [31:0] io_limit_o,
  output reg [7:0] capability_list_head_o,
  output reg [7:0] irq_routing_line_o,
  output wire pf_hit_o,
  output wire io_hit_o
);

  // ========================================================
  // Byte lane merge for partial writes
  function [31:0] merge_lanes;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] strb;
    integer i;
    begin
      merge_lanes = old_val;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge_lanes[i*8 +: 8] = new_val[i*8 +: 8];
        end
      end
    end
  endfunction

  // ========================================================
  // Write strobe for one register index
  function wr_at;
    input en;
    input [9:0] idx;
    input [9:0] target;
    begin
      wr_at = en && (idx == target);
    end
  endfunction

  // ========================================================
  // Storage
  reg [11:0] prefetch_limit_low;
  reg [31:0] prefetch_base_high;
  reg [31:0] prefetch_limit_high;
  reg [15:0] io_base_high;
  reg [15:0] io_limit_high;
  reg prefetch_width_cap;
  reg [7:0] capability_list_head;
  reg [7:0] irq_routing_line;

  wire [9:0] reg_idx;
  wire wr_en;
  reg rd_hit;
  reg [31:0] rd_data;
  wire [31:0] pf_base_high_eff;
  wire [31:0] pf_limit_high_eff;
  wire [15:0] io_base_high_eff;
  wire [15:0] io_limit_high_eff;
  wire [31:0] next_pf_limit_word;
  wire [63:0] next_pf_base;
  wire [63:0] next_pf_limit;
  wire [31:0] next_io_base;
  wire [31:0] next_io_limit;
  wire [31:0] next_wr_word;
  wire wr_pf_limit_low;
  wire wr_pf_base_up;
  wire wr_pf_limit_up;
  wire wr_io_base_up;
  wire wr_io_limit_up;
  wire wr_cap_head;
  wire wr_irq_line;
  wire wr_pf_cap;

  // ========================================================
  // Bus front end
  bwuc_apb_if u_apb (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .rd_data_i(rd_data),
    .rd_hit_i(rd_hit),
    .reg_idx_o(reg_idx),
    .wr_en_o(wr_en),
    .pready_o(pready_o),
    .prdata_o(prdata_o),
    .pslverr_o(pslverr_o)
  );

  // ========================================================
  // Narrow widths hide the upper words
  assign pf_base_high_eff = prefetch_width_cap ? prefetch_base_high : `BWUC_ZERO32;
  assign pf_limit_high_eff = prefetch_width_cap ? prefetch_limit_high : `BWUC_ZERO32;
  assign io_base_high_eff = io_width_cap_i ? io_base_high : 16'h0000;
  assign io_limit_high_eff = io_width_cap_i ? io_limit_high : 16'h0000;

  assign next_pf_limit_word = {16'h0000, prefetch_limit_low, 3'b000,
                               prefetch_width_cap};

  // ========================================================
  // Read decode
  always @* begin
    rd_hit = 1'b1;
    rd_data = `BWUC_ZERO32;
    case (reg_idx)
      `BWUC_IDX_PF_LIMIT_LOW: rd_data = next_pf_limit_word;
      `BWUC_IDX_PF_BASE_UP: rd_data = pf_base_high_eff;
      `BWUC_IDX_PF_LIMIT_UP: rd_data = pf_limit_high_eff;
      `BWUC_IDX_IO_BASE_UP: rd_data = {16'h0000, io_base_high_eff};
      `BWUC_IDX_IO_LIMIT_UP: rd_data = {16'h0000, io_limit_high_eff};
      `BWUC_IDX_CAP_HEAD: rd_data = {24'h000000, capability_list_head};
      `BWUC_IDX_ROM_BASE: rd_data = `BWUC_ZERO32;
      `BWUC_IDX_IRQ_LINE: rd_data = {24'h000000, irq_routing_line};
      `BWUC_IDX_PF_CAP_CTRL: rd_data = {31'h00000000, prefetch_width_cap};
      default: rd_hit = 1'b0;
    endcase
  end

  // ========================================================
  // Register write strobes
  // Addressed word with the written lanes merged in
  assign next_wr_word = merge_lanes(rd_data, pwdata_i, pstrb_i);
  assign wr_pf_limit_low = wr_at(wr_en, reg_idx, `BWUC_IDX_PF_LIMIT_LOW);
  assign wr_pf_base_up = wr_at(wr_en & prefetch_width_cap, reg_idx,
                               `BWUC_IDX_PF_BASE_UP);
  assign wr_pf_limit_up = wr_at(wr_en & prefetch_width_cap, reg_idx,
                                `BWUC_IDX_PF_LIMIT_UP);
  assign wr_io_base_up = wr_at(wr_en & io_width_cap_i, reg_idx,
                               `BWUC_IDX_IO_BASE_UP);
  assign wr_io_limit_up = wr_at(wr_en & io_width_cap_i, reg_idx,
                                `BWUC_IDX_IO_LIMIT_UP);
  assign wr_cap_head = wr_at(wr_en & ~reg_lock_i & pstrb_i[0], reg_idx,
                             `BWUC_IDX_CAP_HEAD);
  assign wr_irq_line = wr_at(wr_en & pstrb_i[0], reg_idx,
                             `BWUC_IDX_IRQ_LINE);
  assign wr_pf_cap = wr_at(wr_en & ~reg_lock_i & pstrb_i[0], reg_idx,
                           `BWUC_IDX_PF_CAP_CTRL);

  // ========================================================
  // One flop group per register
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prefetch_limit_low <= `BWUC_RST_PF_LIMIT_LOW;
    end else if (wr_pf_limit_low) begin
      prefetch_limit_low <= next_wr_word[`BWUC_PF_LIMIT_MSB:`BWUC_PF_LIMIT_LSB];
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prefetch_base_high <= `BWUC_RST_PF_BASE_UP;
    end else if (wr_pf_base_up) begin
      prefetch_base_high <= next_wr_word;
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prefetch_limit_high <= `BWUC_RST_PF_LIMIT_UP;
    end else if (wr_pf_limit_up) begin
      prefetch_limit_high <= next_wr_word;
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      io_base_high <= `BWUC_RST_IO_BASE_UP;
    end else if (wr_io_base_up) begin
      io_base_high <= next_wr_word[15:0];
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      io_limit_high <= `BWUC_RST_IO_LIMIT_UP;
    end else if (wr_io_limit_up) begin
      io_limit_high <= next_wr_word[15:0];
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      capability_list_head <= `BWUC_RST_CAP_HEAD;
    end else if (wr_cap_head) begin
      capability_list_head <= pwdata_i[7:0];
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      irq_routing_line <= `BWUC_RST_IRQ_LINE;
    end else if (wr_irq_line) begin
      irq_routing_line <= pwdata_i[7:0];
    end
  end

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prefetch_width_cap <= `BWUC_RST_PF_CAP;
    end else if (wr_pf_cap) begin
      prefetch_width_cap <= pwdata_i[`BWUC_CAP_BIT];
    end
  end

  // ========================================================
  // Full window bounds
  assign next_pf_base = {pf_base_high_eff, prefetch_base_low_i,
                         `BWUC_MEM_LOW_ZERO};
  assign next_pf_limit = {pf_limit_high_eff, prefetch_limit_low,
                          `BWUC_MEM_LOW_FILL};
  assign next_io_base = {io_base_high_eff, io_base_low_i, `BWUC_IO_LOW_ZERO};
  assign next_io_limit = {io_limit_high_eff, io_limit_low_i, `BWUC_IO_LOW_FILL};

  // ========================================================
  // Window bounds, one cycle behind the registers
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pf_base_o <= `BWUC_RST_PF_BASE;
      pf_limit_o <= `BWUC_RST_PF_LIMIT;
      io_base_o <= `BWUC_RST_IO_BASE;
      io_limit_o <= `BWUC_RST_IO_LIMIT;
    end else begin
      pf_base_o <= next_pf_base;
      pf_limit_o <= next_pf_limit;
      io_base_o <= next_io_base;
      io_limit_o <= next_io_limit;
    end
  end

  // ========================================================
  // Registered copies for neighbouring logic
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      prefetch_width_cap_o <= `BWUC_RST_PF_CAP;
      capability_list_head_o <= `BWUC_RST_CAP_HEAD;
      irq_routing_line_o <= `BWUC_RST_IRQ_LINE;
    end else begin
      prefetch_width_cap_o <= prefetch_width_cap;
      capability_list_head_o <= capability_list_head;
      irq_routing_line_o <= irq_routing_line;
    end
  end

  // ========================================================
  // Address match for forwarding
  bwuc_win_match #(.AW(64)) u_pf_match (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .addr_i(mem_addr_i),
    .base_i(pf_base_o),
    .limit_i(pf_limit_o),
    .hit_o(pf_hit_o)
  );

  bwuc_win_match #(.AW(32)) u_io_match (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .addr_i(io_addr_i),
    .base_i(io_base_o),
    .limit_i(io_limit_o),
    .hit_o(io_hit_o)
  );

endmodule // bwuc_regs
`default_nettype wire

// >>> design/bwuc_defines.vh
`ifndef BWUC_DEFINES_VH
`define BWUC_DEFINES_VH

// ==========================================================
// Register indices (byte address is four times the index)
`define BWUC_IDX_PF_LIMIT_LOW 10'h026
`define BWUC_IDX_PF_BASE_UP 10'h028
`define BWUC_IDX_PF_LIMIT_UP 10'h02c
`define BWUC_IDX_IO_BASE_UP 10'h030
`define BWUC_IDX_IO_LIMIT_UP 10'h032
`define BWUC_IDX_CAP_HEAD 10'h034
`define BWUC_IDX_ROM_BASE 10'h038
`define BWUC_IDX_IRQ_LINE 10'h03c
`define BWUC_IDX_PF_CAP_CTRL 10'h080

// ==========================================================
// Reset values
`define BWUC_RST_PF_LIMIT_LOW 12'h000
`define BWUC_RST_PF_BASE_UP 32'hffffffff
`define BWUC_RST_PF_LIMIT_UP 32'h00000000
`define BWUC_RST_IO_BASE_UP 16'hffff
`define BWUC_RST_IO_LIMIT_UP 16'h0000
`define BWUC_RST_CAP_HEAD 8'h40
`define BWUC_RST_IRQ_LINE 8'h00
`define BWUC_RST_PF_CAP 1'b1
`define BWUC_RST_PF_BASE 64'hffffffff_00000000
`define BWUC_RST_PF_LIMIT 64'h00000000_000fffff
`define BWUC_RST_IO_BASE 32'hffff0000
`define BWUC_RST_IO_LIMIT 32'h00000fff

// ==========================================================
// Field positions and fills
`define BWUC_PF_LIMIT_MSB 15
`define BWUC_PF_LIMIT_LSB 4
`define BWUC_CAP_BIT 0
`define BWUC_MEM_LOW_FILL 20'hfffff
`define BWUC_MEM_LOW_ZERO 20'h00000
`define BWUC_IO_LOW_FILL 12'hfff
`define BWUC_IO_LOW_ZERO 12'h000
`define BWUC_ZERO32 32'h00000000

`endif

// >>> design/bwuc_apb_if.v
`timescale 1ns/10ps
`default_nettype none
`include "bwuc_defines.vh"
// ==========================================================
// APB slave: one wait state, registered answer
module bwuc_apb_if (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] rd_data_i,
  input wire rd_hit_i,
  output wire [9:0] reg_idx_o,
  output wire wr_en_o,
  output reg pready_o,
  output reg [31:0] prdata_o,
  output reg pslverr_o
);
  wire access_wait;

  assign reg_idx_o = paddr_i[11:2];
  assign access_wait = psel_i & penable_i & ~pready_o;
  // Write lands at the edge where pready is sampled high
  assign wr_en_o = psel_i & penable_i & pready_o & pwrite_i & rd_hit_i;

  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      pready_o <= 1'b0;
      prdata_o <= `BWUC_ZERO32;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= access_wait;
      pslverr_o <= access_wait & ~rd_hit_i;
      if (access_wait && !pwrite_i && rd_hit_i) begin
        prdata_o <= rd_data_i;
      end else if (access_wait) begin
        prdata_o <= `BWUC_ZERO32;
      end
    end
  end
endmodule // bwuc_apb_if
`default_nettype wire

// >>> design/bwuc_win_match.v
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// Inclusive window compare, registered result
module bwuc_win_match #(
  parameter AW = 64
) (
  input wire clk_sys_i,
  input wire rst_n_i,
  input wire [AW-1:0] addr_i,
  input wire [AW-1:0] base_i,
  input wire [AW-1:0] limit_i,
  output reg hit_o
);
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      hit_o <= 1'b0;
    end else begin
      hit_o <= (addr_i >= base_i) && (addr_i <= limit_i);
    end
  end
endmodule // bwuc_win_match
`default_nettype wire

// >>> bench/bwuc_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module bwuc_chk (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic pready_o,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  input wire logic reg_lock_i,
  input wire logic io_width_cap_i,
  input wire logic [63:0] mem_addr_i,
  input wire logic [31:0] io_addr_i,
  input wire logic prefetch_width_cap_o,
  input wire logic [63:0] pf_base_o,
  input wire logic [63:0] pf_limit_o,
  input wire logic [31:0] io_base_o,
  input wire logic [31:0] io_limit_o,
  input wire logic [7:0] capability_list_head_o,
  input wire logic pf_hit_o,
  input wire logic io_hit_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  wire rdv = pready_o && !pwrite_i;
  wire [9:0] ix = paddr_i[11:2];
  property p_mirror; rdv && ix == 10'h026 |-> prdata_o[3:0] == {3'h0, prefetch_width_cap_o};
  endproperty
  a_mirror: assert property (p_mirror) else $error("limit word low bits wrong");
  property p_fill; pf_limit_o[19:0] == 20'hfffff && pf_base_o[19:0] == 20'h0; endproperty
  a_fill: assert property (p_fill) else $error("prefetch low fill wrong");
  property p_pfu; rdv && !prefetch_width_cap_o && (ix == 10'h028 || ix == 10'h02c)
    |-> prdata_o == 32'h0; endproperty
  a_pfu: assert property (p_pfu) else $error("prefetch upper not zero");
  property p_iou; rdv && !io_width_cap_i && (ix == 10'h030 || ix == 10'h032)
    |-> prdata_o == 32'h0; endproperty
  a_iou: assert property (p_iou) else $error("io upper not zero");
  property p_rom; rdv && ix == 10'h038 |-> prdata_o == 32'h0 && !pslverr_o; endproperty
  a_rom: assert property (p_rom) else $error("option rom not zero");
  property p_pfhit; pf_hit_o == ($past(mem_addr_i) >= $past(pf_base_o)
    && $past(mem_addr_i) <= $past(pf_limit_o)); endproperty
  a_pfhit: assert property (p_pfhit) else $error("prefetch hit wrong");
  property p_iohit; io_hit_o == ($past(io_addr_i) >= $past(io_base_o)
    && $past(io_addr_i) <= $past(io_limit_o)); endproperty
  a_iohit: assert property (p_iohit) else $error("io hit wrong");
  property p_lock; reg_lock_i && $past(reg_lock_i) && $past(reg_lock_i, 2)
    |-> $stable(capability_list_head_o) && $stable(prefetch_width_cap_o); endproperty
  a_lock: assert property (p_lock) else $error("locked field changed");
  property p_rdy; psel_i && penable_i && !$past(penable_i)
    |-> !pready_o ##1 pready_o ##1 !pready_o; endproperty
  a_rdy: assert property (p_rdy) else $error("ready timing wrong");
endmodule // bwuc_chk
bind bwuc_regs bwuc_chk chk_i (.clk_sys_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i,
  .paddr_i, .pready_o, .prdata_o, .pslverr_o, .reg_lock_i, .io_width_cap_i, .mem_addr_i,
  .io_addr_i, .prefetch_width_cap_o, .pf_base_o, .pf_limit_o, .io_base_o, .io_limit_o,
  .capability_list_head_o, .pf_hit_o, .io_hit_o);
`default_nettype wire

// >>> bench/bridge_window_upper_cfg_regs_bench.sv
`timescale 1ns/10ps
`default_nettype none
module bridge_window_upper_cfg_regs_bench;
  logic clk_sys_i, rst_n_i, psel_i, penable_i, pwrite_i, reg_lock_i, io_width_cap_i, er;
  logic [11:0] paddr_i, prefetch_base_low_i;
  logic [31:0] pwdata_i, io_addr_i, rd;
  logic [3:0] pstrb_i, io_base_low_i, io_limit_low_i;
  logic [63:0] mem_addr_i;
  wire pready_o, pslverr_o, prefetch_width_cap_o, pf_hit_o, io_hit_o;
  wire [31:0] prdata_o, io_base_o, io_limit_o;
  wire [63:0] pf_base_o, pf_limit_o;
  wire [7:0] capability_list_head_o, irq_routing_line_o;
  int bad_count, compares;
  bwuc_regs uut (.clk_sys_i, .rst_n_i, .psel_i, .penable_i, .pwrite_i, .paddr_i, .pwdata_i,
    .pstrb_i, .pready_o, .prdata_o, .pslverr_o, .reg_lock_i, .prefetch_base_low_i,
    .io_width_cap_i, .io_base_low_i, .io_limit_low_i, .mem_addr_i, .io_addr_i,
    .prefetch_width_cap_o, .pf_base_o, .pf_limit_o, .io_base_o, .io_limit_o,
    .capability_list_head_o, .irq_routing_line_o, .pf_hit_o, .io_hit_o);
  initial begin
    clk_sys_i = 0;
    forever #2.5 clk_sys_i = ~clk_sys_i;
  end
  // ==========================================================
  // Bus and compare helpers
  task chk(input [63:0] g, input [63:0] x);
    compares++;
    if (g !== x) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  task apb(input bit w, input [11:0] a, input [31:0] d);
    psel_i <= 1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i) penable_i <= 1;
    do @(posedge clk_sys_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i <= 0;
    penable_i <= 0;
    @(posedge clk_sys_i);
  endtask
  task wr(input [11:0] a, input [31:0] d);
    apb(1, a, d);
  endtask
  task rc(input [11:0] a, input [31:0] x);
    apb(0, a, 32'h0);
    chk(rd, x);
  endtask
  task hit(input [63:0] a, input [31:0] ia, input [1:0] x);
    mem_addr_i <= a;
    io_addr_i <= ia;
    repeat (2) @(posedge clk_sys_i);
    chk({pf_hit_o, io_hit_o}, x);
  endtask
  // ==========================================================
  // Scenarios
  task t_reset;
    rc(12'h098, 32'h1);
    rc(12'h0a0, 32'hffffffff);
    rc(12'h0b0, 32'h0);
    rc(12'h0c0, 32'hffff);
    rc(12'h0c8, 32'h0);
    rc(12'h0d0, 32'h40);
    rc(12'h0f0, 32'h0);
    chk(pf_limit_o, 64'hfffff);
    $display("t_reset done");
  endtask
  task t_regs;
    wr(12'h098, 32'hfffffffe);
    rc(12'h098, 32'hfff1);
    wr(12'h0e0, 32'hffffffff);
    rc(12'h0e0, 32'h0);
    wr(12'h0f0, 32'ha5);
    rc(12'h0f0, 32'ha5);
    chk(irq_routing_line_o, 8'ha5);
    apb(0, 12'h100, 32'h0);
    chk({er, rd}, {1'b1, 32'h0});
    $display("t_regs done");
  endtask
  task t_window;
    prefetch_base_low_i <= 12'h123;
    io_base_low_i <= 4'h2;
    io_limit_low_i <= 4'h3;
    wr(12'h0a0, 32'h1);
    wr(12'h0b0, 32'h1);
    wr(12'h098, 32'h1240);
    wr(12'h0c0, 32'h1);
    wr(12'h0c8, 32'h1);
    repeat (2) @(posedge clk_sys_i);
    chk(pf_base_o, 64'h1_12300000);
    chk(pf_limit_o, 64'h1_124fffff);
    chk(io_base_o, 32'h12000);
    chk(io_limit_o, 32'h13fff);
    hit(64'h1_12300000, 32'h12000, 2'b11);
    hit(64'h1_122fffff, 32'h11fff, 2'b00);
    hit(64'h1_124fffff, 32'h13fff, 2'b11);
    hit(64'h1_12500000, 32'h14000, 2'b00);
    $display("t_window done");
  endtask
  task t_cap;
    wr(12'h200, 32'h0);
    rc(12'h098, 32'h1240);
    rc(12'h0a0, 32'h0);
    chk(prefetch_width_cap_o, 1'b0);
    chk(pf_base_o, 64'h12300000);
    wr(12'h0b0, 32'h5);
    wr(12'h200, 32'h1);
    rc(12'h0b0, 32'h1);
    io_width_cap_i <= 0;
    rc(12'h0c0, 32'h0);
    wr(12'h0c8, 32'h7);
    io_width_cap_i <= 1;
    rc(12'h0c8, 32'h1);
    pstrb_i <= 4'h2;
    wr(12'h0a0, 32'h0000ab00);
    pstrb_i <= 4'hf;
    rc(12'h0a0, 32'h0000ab01);
    $display("t_cap done");
  endtask
  task t_lock;
    reg_lock_i <= 1;
    wr(12'h0d0, 32'h80);
    wr(12'h200, 32'h0);
    rc(12'h0d0, 32'h40);
    rc(12'h098, 32'h1241);
    reg_lock_i <= 0;
    wr(12'h0d0, 32'h80);
    rc(12'h0d0, 32'h80);
    chk(capability_list_head_o, 8'h80);
    $display("t_lock done");
  endtask
  task t_rst2;
    wr(12'h200, 32'h0);
    rst_n_i <= 0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1;
    @(posedge clk_sys_i);
    rc(12'h098, 32'h1);
    rc(12'h0a0, 32'hffffffff);
    rc(12'h0c0, 32'hffff);
    chk(prefetch_width_cap_o, 1'b1);
    $display("t_rst2 done");
  endtask
  task results;
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    {rst_n_i, psel_i, penable_i, pwrite_i, reg_lock_i} <= 5'h0;
    {paddr_i, pwdata_i, io_addr_i, mem_addr_i} <= 0;
    pstrb_i <= 4'hf;
    io_width_cap_i <= 1;
    {prefetch_base_low_i, io_base_low_i, io_limit_low_i} <= 0;
    repeat (10) @(posedge clk_sys_i);
    rst_n_i <= 1;
    @(posedge clk_sys_i);
    t_reset;
    t_regs;
    t_window;
    t_cap;
    t_lock;
    t_rst2;
    results;
  end
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    bad_count++;
    results;
  end
endmodule // bridge_window_upper_cfg_regs_bench
`default_nettype wire
